// File: pkg/ibc_cfg.svh
`ifndef IBC_CFG_SVH
`define IBC_CFG_SVH

`define IBC_ADDR_ACC 12'h0E4
`define IBC_ADDR_CSR0 12'h0E8
`define IBC_ADDR_CSR1 12'h0EC

`define IBC_WCLR_BIT 30
`define IBC_WPTR_LSB 24
`define IBC_RCLR_BIT 22
`define IBC_RPTR_LSB 16
`define IBC_TGT_LSB 8
`define IBC_FILL_BIT 7
`define IBC_EN_BIT 6
`define IBC_LEN_LSB 0
`define IBC_GAP_LSB 0

`define IBC_CSR0_RST 32'h0000_0000
`define IBC_CSR1_RST 32'h0000_0000
`define IBC_FILL_WORD 32'hFFFF_FFFF
`define IBC_PTR_LAST 6'h3F

`define IBC_OFFS_PER_CYCLE 17'h0C00
`define IBC_TIMER_SPAN 17'h0C000

`define IBC_RESP_OKAY 2'h0
`define IBC_RESP_SLVERR 2'h2

`endif

// File: pkg/ibc_pkg.sv
package ibc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_SEND,
        ST_FILL
    } ibc_state_t;

    typedef struct packed {
        logic [2:0] target;
        logic last;
        logic [31:0] data;
    } ibc_word_t;

    typedef struct packed {
        logic [3:0] cycles;
        logic [11:0] offset;
    } ibc_time_t;

endpackage : ibc_pkg

// File: verilog/ibc_fifo.sv
`timescale 1ns/100ps
module ibc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,                // system clock
    input wire logic rst_n_i,              // async reset, active low
    input wire logic [WIDTH-1:0] in_data_i, // word to store
    input wire logic in_valid_i,           // store request
    output logic in_ready_o,               // room for one word
    output logic [WIDTH-1:0] out_data_o,   // head word
    output logic out_valid_o,              // head word present
    input wire logic out_ready_i           // head word taken
);

    // shift-register form so head data and flags are plain flip-flops
    logic [WIDTH-1:0] slot_r [DEPTH];
    logic [DEPTH-1:0] vld_r;
    logic push;
    logic pop;
    int unsigned idx;

    assign push = in_valid_i && !vld_r[DEPTH-1];
    assign pop = out_ready_i && vld_r[0];
    assign in_ready_o = !vld_r[DEPTH-1];
    assign out_valid_o = vld_r[0];
    assign out_data_o = slot_r[0];

    always_comb
    begin
        idx = 0;
        for (int i = 0; i < DEPTH; i++)
        begin
            if (vld_r[i])
            begin
                idx = pop ? i : i + 1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            vld_r <= '0;
            for (int i = 0; i < DEPTH; i++)
            begin
                slot_r[i] <= '0;
            end
        end
        else
        begin
            if (pop)
            begin
                for (int i = 0; i < DEPTH - 1; i++)
                begin
                    slot_r[i] <= slot_r[i+1];
                    vld_r[i] <= vld_r[i+1];
                end
                vld_r[DEPTH-1] <= 1'b0;
            end
            if (push)
            begin
                slot_r[idx] <= in_data_i;
                vld_r[idx] <= 1'b1;
            end
        end
    end

endmodule : ibc_fifo

// File: verilog/ibc_top.sv
// Function
// - pointer-clear write zeroes write pointer when disabled; self-clears; ignored when enabled
// - pointer-clear write zeroes read pointer when disabled; self-clears; ignored when enabled
// - six-bit write pointer readable; steps on each access write while disabled and no ones-fill is running
// - six-bit read pointer readable; names location the next access read returns
// - while enabled, read pointer shows location being fetched for insertion
// - ones-fill write fills RAM from write pointer to end with all ones
// - enable write zeroes both pointers; starts insertion only when no ones-fill is running
// - hardware clears enable after a packet is inserted
// - insert packet once stream gap reaches sixteen-bit threshold
// - threshold is cycle-timer format: four cycle bits, twelve offset bits
// - reserved bits ignore writes and read zero
// - access write stores at write pointer only while disabled
// - RAM has no reset; software loads or fills it first
`timescale 1ns/100ps
`include "ibc_cfg.svh"
module ibc_top
    import ibc_pkg::*;
(
    input wire logic SYS_CLK_I,            // 20 MHz system clock
    input wire logic RST_N_I,              // async reset, active low
    input wire logic [11:0] AWADDR_I,      // write address
    input wire logic AWVALID_I,            // write address valid
    output logic AWREADY_O,                // write address ready
    input wire logic [31:0] WDATA_I,       // write data
    input wire logic [3:0] WSTRB_I,        // write byte lanes
    input wire logic WVALID_I,             // write data valid
    output logic WREADY_O,                 // write data ready
    output logic [1:0] BRESP_O,            // write response
    output logic BVALID_O,                 // write response valid
    input wire logic BREADY_I,             // write response ready
    input wire logic [11:0] ARADDR_I,      // read address
    input wire logic ARVALID_I,            // read address valid
    output logic ARREADY_O,                // read address ready
    output logic [31:0] RDATA_O,           // read data
    output logic [1:0] RRESP_O,            // read response
    output logic RVALID_O,                 // read data valid
    input wire logic RREADY_I,             // read data ready
    input wire logic TS_ACTIVE_I,          // stream pin: packet bytes arriving
    input wire logic [15:0] CYCLE_TIME_I,  // link cycle timer, low 16 bits
    output logic [31:0] TX_DATA_O,         // inserted quadlet
    output logic [2:0] TX_BUF_O,           // target data buffer
    output logic TX_LAST_O,                // last quadlet of packet
    output logic TX_VALID_O,               // quadlet valid
    input wire logic TX_READY_I            // buffer engine accepts quadlet
);

    logic [31:0] mem [64];
    logic aw_rdy_r;
    logic w_rdy_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic [11:0] aw_addr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic ar_rdy_r;
    logic rd_go_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [11:0] ar_addr_r;
    logic en_r;
    logic [2:0] target_r;
    logic [5:0] len_r;
    ibc_time_t gap_thr_r;
    logic [5:0] wr_ptr_r;
    logic [5:0] rd_ptr_r;
    logic [5:0] sent_r;
    ibc_state_t st_r;
    logic ts_s1_r;
    logic ts_s2_r;
    ibc_time_t last_seen_r;
    logic wr_go;
    logic csr0_wr;
    logic csr1_wr;
    logic acc_wr;
    logic acc_rd;
    logic en_set;
    logic wclr;
    logic rclr;
    logic fill_go;
    logic push;
    logic done;
    logic gap_met;
    logic fifo_rdy;
    logic [16:0] now_lin;
    logic [16:0] last_lin;
    logic [16:0] thr_lin;
    logic [16:0] gap_lin;
    ibc_word_t push_word;
    ibc_word_t head_word;

    // write path: address and data are taken in either order
    assign wr_go = !aw_rdy_r && !w_rdy_r && !bvalid_r;
    assign csr0_wr = wr_go && (aw_addr_r == `IBC_ADDR_CSR0);
    assign csr1_wr = wr_go && (aw_addr_r == `IBC_ADDR_CSR1);
    assign acc_wr = wr_go && (aw_addr_r == `IBC_ADDR_ACC) && !en_r && (st_r != ST_FILL);
    assign acc_rd = rd_go_r && (ar_addr_r == `IBC_ADDR_ACC) && !en_r;
    assign en_set = csr0_wr && wstrb_r[0] && wdata_r[`IBC_EN_BIT] && !en_r;
    assign wclr = csr0_wr && wstrb_r[3] && wdata_r[`IBC_WCLR_BIT] && !en_r;
    assign rclr = csr0_wr && wstrb_r[2] && wdata_r[`IBC_RCLR_BIT] && !en_r;
    assign fill_go = csr0_wr && wstrb_r[0] && wdata_r[`IBC_FILL_BIT] && !en_r
        && (st_r == ST_IDLE);

    assign AWREADY_O = aw_rdy_r;
    assign WREADY_O = w_rdy_r;
    assign BVALID_O = bvalid_r;
    assign BRESP_O = bresp_r;
    assign ARREADY_O = ar_rdy_r;
    assign RVALID_O = rvalid_r;
    assign RRESP_O = rresp_r;
    assign RDATA_O = rdata_r;

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            aw_rdy_r <= 1'b1;
            w_rdy_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `IBC_RESP_OKAY;
            aw_addr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end
        else
        begin
            if (AWVALID_I && aw_rdy_r)
            begin
                aw_addr_r <= {AWADDR_I[11:2], 2'h0};
                aw_rdy_r <= 1'b0;
            end
            if (WVALID_I && w_rdy_r)
            begin
                wdata_r <= WDATA_I;
                wstrb_r <= WSTRB_I;
                w_rdy_r <= 1'b0;
            end
            if (wr_go)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= (csr0_wr || csr1_wr || aw_addr_r == `IBC_ADDR_ACC) ?
                    `IBC_RESP_OKAY : `IBC_RESP_SLVERR;
            end
            if (bvalid_r && BREADY_I)
            begin
                bvalid_r <= 1'b0;
                aw_rdy_r <= 1'b1;
                w_rdy_r <= 1'b1;
            end
        end
    end

    // read path: data answered two cycles after the address is taken
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ar_rdy_r <= 1'b1;
            rd_go_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= `IBC_RESP_OKAY;
            rdata_r <= '0;
            ar_addr_r <= '0;
        end
        else
        begin
            rd_go_r <= 1'b0;
            if (ARVALID_I && ar_rdy_r)
            begin
                ar_addr_r <= {ARADDR_I[11:2], 2'h0};
                ar_rdy_r <= 1'b0;
                rd_go_r <= 1'b1;
            end
            if (rd_go_r)
            begin
                rvalid_r <= 1'b1;
                rresp_r <= `IBC_RESP_OKAY;
                case (ar_addr_r)
                    `IBC_ADDR_ACC: rdata_r <= en_r ? 32'h0000_0000 : mem[rd_ptr_r];
                    `IBC_ADDR_CSR0: rdata_r <= {2'h0, wr_ptr_r, 2'h0, rd_ptr_r, 5'h00,
                        target_r, 1'b0, en_r, len_r};
                    `IBC_ADDR_CSR1: rdata_r <= {16'h0000, gap_thr_r};
                    default:
                    begin
                        rdata_r <= '0;
                        rresp_r <= `IBC_RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid_r && RREADY_I)
            begin
                rvalid_r <= 1'b0;
                ar_rdy_r <= 1'b1;
            end
        end
    end

    // configuration fields; reserved bits are simply not stored
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            target_r <= 3'(`IBC_CSR0_RST >> `IBC_TGT_LSB);
            len_r <= 6'(`IBC_CSR0_RST >> `IBC_LEN_LSB);
            gap_thr_r <= 16'(`IBC_CSR1_RST >> `IBC_GAP_LSB);
        end
        else
        begin
            if (csr0_wr && wstrb_r[1])
            begin
                target_r <= wdata_r[`IBC_TGT_LSB +: 3];
            end
            if (csr0_wr && wstrb_r[0])
            begin
                len_r <= wdata_r[`IBC_LEN_LSB +: 6];
            end
            if (csr1_wr && wstrb_r[0])
            begin
                gap_thr_r[7:0] <= wdata_r[7:0];
            end
            if (csr1_wr && wstrb_r[1])
            begin
                gap_thr_r[15:8] <= wdata_r[15:8];
            end
        end
    end

    // enable: a new set wins over the hardware clear
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            en_r <= 1'b0;
        end
        else if (en_set)
        begin
            en_r <= 1'b1;
        end
        else if (done)
        begin
            en_r <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            wr_ptr_r <= '0;
        end
        else if (en_set || wclr)
        begin
            wr_ptr_r <= '0;
        end
        else if (st_r == ST_FILL || acc_wr)
        begin
            wr_ptr_r <= wr_ptr_r + 6'h01;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rd_ptr_r <= '0;
        end
        else if (en_set || rclr)
        begin
            rd_ptr_r <= '0;
        end
        else if (push || acc_rd)
        begin
            rd_ptr_r <= rd_ptr_r + 6'h01;
        end
    end

    // no reset on the RAM: contents are undefined until loaded or filled
    always_ff @(posedge SYS_CLK_I)
    begin
        if (st_r == ST_FILL)
        begin
            mem[wr_ptr_r] <= `IBC_FILL_WORD;
        end
        else if (acc_wr)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (wstrb_r[b])
                begin
                    mem[wr_ptr_r][8*b +: 8] <= wdata_r[8*b +: 8];
                end
            end
        end
    end

    // stream activity pin is asynchronous
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ts_s1_r <= 1'b0;
            ts_s2_r <= 1'b0;
            last_seen_r <= '0;
        end
        else
        begin
            ts_s1_r <= TS_ACTIVE_I;
            ts_s2_r <= ts_s1_r;
            if (ts_s2_r)
            begin
                last_seen_r <= CYCLE_TIME_I;
            end
        end
    end

    // gaps longer than sixteen bus cycles alias; the timer span wraps
    assign now_lin = 17'(CYCLE_TIME_I[15:12]) * `IBC_OFFS_PER_CYCLE
        + 17'(CYCLE_TIME_I[11:0]);
    assign last_lin = 17'(last_seen_r.cycles) * `IBC_OFFS_PER_CYCLE
        + 17'(last_seen_r.offset);
    assign thr_lin = 17'(gap_thr_r.cycles) * `IBC_OFFS_PER_CYCLE
        + 17'(gap_thr_r.offset);
    assign gap_lin = (now_lin >= last_lin) ? now_lin - last_lin
        : now_lin + `IBC_TIMER_SPAN - last_lin;
    assign gap_met = !ts_s2_r && (gap_lin >= thr_lin);

    assign push = (st_r == ST_SEND) && fifo_rdy;
    assign done = (push && push_word.last) || ((st_r == ST_WAIT) && gap_met && len_r == 6'h00);
    assign push_word = '{target: target_r, last: (sent_r == len_r - 6'h01),
        data: mem[rd_ptr_r]};

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            st_r <= ST_IDLE;
            sent_r <= '0;
        end
        else
        begin
            case (st_r)
                ST_IDLE:
                begin
                    sent_r <= '0;
                    if (en_set)
                    begin
                        st_r <= ST_WAIT;
                    end
                    else if (fill_go)
                    begin
                        st_r <= ST_FILL;
                    end
                end
                ST_WAIT:
                begin
                    if (gap_met)
                    begin
                        st_r <= (len_r == 6'h00) ? ST_IDLE : ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    if (push)
                    begin
                        sent_r <= sent_r + 6'h01;
                        if (push_word.last)
                        begin
                            st_r <= ST_IDLE;
                        end
                    end
                end
                ST_FILL:
                begin
                    if (wr_ptr_r == `IBC_PTR_LAST)
                    begin
                        st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    ibc_fifo #(
        .WIDTH($bits(ibc_word_t)),
        .DEPTH(4)
    ) u_fifo (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .in_data_i(push_word),
        .in_valid_i(st_r == ST_SEND),
        .in_ready_o(fifo_rdy),
        .out_data_o(head_word),
        .out_valid_o(TX_VALID_O),
        .out_ready_i(TX_READY_I)
    );

    assign TX_DATA_O = head_word.data;
    assign TX_BUF_O = head_word.target;
    assign TX_LAST_O = head_word.last;

endmodule : ibc_top

// File: test/ibc_top_properties.sv
`timescale 1ns/100ps
module ibc_top_checker (
    input wire logic SYS_CLK_I, // clock
    input wire logic RST_N_I, // reset, active low
    input wire logic [11:0] AWADDR_I, // write address
    input wire logic AWVALID_I, // aw valid
    input wire logic AWREADY_O, // aw ready
    input wire logic WVALID_I, // w valid
    input wire logic WREADY_O, // w ready
    input wire logic [1:0] BRESP_O, // write response
    input wire logic BVALID_O, // b valid
    input wire logic [11:0] ARADDR_I, // read address
    input wire logic ARVALID_I, // ar valid
    input wire logic ARREADY_O, // ar ready
    input wire logic [31:0] RDATA_O, // read data
    input wire logic [1:0] RRESP_O, // read response
    input wire logic RVALID_O, // r valid
    input wire logic [31:0] TX_DATA_O, // inserted quadlet
    input wire logic TX_VALID_O, // quadlet valid
    input wire logic TX_READY_I // downstream ready
);
    logic aw_ok_r;
    logic ar_ok_r;

    function automatic logic mapped(input logic [11:0] a);
        return a[11:2] inside {10'h039, 10'h03A, 10'h03B};
    endfunction : mapped

    // address kept from its take, answer may come cycles later
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
        if (!RST_N_I) aw_ok_r <= 1'b0;
        else if (AWVALID_I && AWREADY_O) aw_ok_r <= mapped(AWADDR_I);

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
        if (!RST_N_I) ar_ok_r <= 1'b0;
        else if (ARVALID_I && ARREADY_O) ar_ok_r <= mapped(ARADDR_I);

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence s_aw_take;
        AWVALID_I && AWREADY_O;
    endsequence
    sequence s_ar_take;
        ARVALID_I && ARREADY_O;
    endsequence
    sequence s_r_answer;
        !RVALID_O ##1 RVALID_O;
    endsequence

    a_write_answer: assert property (s_aw_take ##0 (WVALID_I && WREADY_O) |=>
        !BVALID_O ##1 BVALID_O)
        else $error("write response late");
    a_aw_held_off: assert property (s_aw_take |=> !AWREADY_O)
        else $error("write address taken twice");
    a_read_answer: assert property (s_ar_take |=> s_r_answer)
        else $error("read answer not two cycles after take");
    a_ar_held_off: assert property (s_ar_take |=> !ARREADY_O [*2])
        else $error("read address ready too soon");
    a_bresp_map: assert property ($rose(BVALID_O) |-> BRESP_O == (aw_ok_r ? 2'h0 : 2'h2))
        else $error("write response code wrong");
    a_rresp_map: assert property ($rose(RVALID_O) |->
        RRESP_O == (ar_ok_r ? 2'h0 : 2'h2) && (ar_ok_r || RDATA_O == 32'h0000_0000))
        else $error("read response code wrong");
    a_tx_stands: assert property (TX_VALID_O && !TX_READY_I |=>
        TX_VALID_O && $stable(TX_DATA_O))
        else $error("quadlet dropped before taken");
    a_reset_ready: assert property (!$past(RST_N_I) |->
        AWREADY_O && ARREADY_O && !BVALID_O && !TX_VALID_O)
        else $error("bad state after reset");
endmodule : ibc_top_checker

bind ibc_top ibc_top_checker u_chk (.SYS_CLK_I, .RST_N_I, .AWADDR_I, .AWVALID_I, .AWREADY_O,
    .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O,
    .RRESP_O, .RVALID_O, .TX_DATA_O, .TX_VALID_O, .TX_READY_I);

// File: test/ibc_stream_model.sv
`timescale 1ns/100ps
module ibc_stream_model (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset, active low
    input wire logic active_cmd_i, // stream busy
    input wire logic slow_i, // stall three cycles of four
    input wire logic [31:0] tx_data_i, // quadlet
    input wire logic [2:0] tx_buf_i, // target buffer
    input wire logic tx_last_i, // last quadlet
    input wire logic tx_valid_i, // quadlet valid
    output logic ts_active_o, // stream pin
    output logic tx_ready_o, // buffer accepts
    output logic [15:0] cycle_time_o // cycle timer
);
    logic [31:0] rx_data [0:15];
    logic [2:0] rx_buf [0:15];
    logic rx_last [0:15];
    logic [11:0] offs_r;
    logic [3:0] cyc_r;
    int rx_n;
    int clk_n;
    int first_at;

    assign ts_active_o = active_cmd_i;
    assign tx_ready_o = !slow_i || (clk_n[1:0] == 2'b00);
    assign cycle_time_o = {cyc_r, offs_r};

    // one offset tick per clock keeps gap arithmetic in clocks
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            offs_r <= 12'h000;
            cyc_r <= 4'h0;
        end
        else if (offs_r == 12'hBFF)
        begin
            offs_r <= 12'h000;
            cyc_r <= cyc_r + 4'h1;
        end
        else offs_r <= offs_r + 12'h001;

    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            rx_n <= 0;
            clk_n <= 0;
            first_at <= 0;
        end
        else
        begin
            clk_n <= clk_n + 1;
            if (tx_valid_i && first_at == 0) first_at <= clk_n;
            if (tx_valid_i && tx_ready_o && rx_n < 16)
            begin
                rx_data[rx_n] <= tx_data_i;
                rx_buf[rx_n] <= tx_buf_i;
                rx_last[rx_n] <= tx_last_i;
                rx_n <= rx_n + 1;
            end
        end
endmodule : ibc_stream_model

// File: test/tb_ibc_top.sv
`timescale 1ns/100ps
`include "ibc_cfg.svh"
module tb_ibc_top;
    logic [11:0] AWADDR_I, ARADDR_I;
    logic [31:0] WDATA_I, RDATA_O, TX_DATA_O, d;
    logic [1:0] BRESP_O, RRESP_O, r;
    logic [3:0] WSTRB_I;
    logic [15:0] CYCLE_TIME_I;
    logic [2:0] TX_BUF_O;
    logic SYS_CLK_I, RST_N_I, AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
    logic ARVALID_I, ARREADY_O, RVALID_O, RREADY_I, TS_ACTIVE_I, TX_LAST_O, TX_VALID_O;
    logic TX_READY_I, ts_on, slow;
    int err_count, n_compared, cyc;

    ibc_top DUT (.SYS_CLK_I, .RST_N_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I, .WSTRB_I,
        .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O,
        .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .TS_ACTIVE_I, .CYCLE_TIME_I, .TX_DATA_O,
        .TX_BUF_O, .TX_LAST_O, .TX_VALID_O, .TX_READY_I);
    ibc_stream_model u_far (.clk_i(SYS_CLK_I), .rst_n_i(RST_N_I), .active_cmd_i(ts_on),
        .slow_i(slow), .tx_data_i(TX_DATA_O), .tx_buf_i(TX_BUF_O), .tx_last_i(TX_LAST_O),
        .tx_valid_i(TX_VALID_O), .ts_active_o(TS_ACTIVE_I), .tx_ready_o(TX_READY_I),
        .cycle_time_o(CYCLE_TIME_I));

    initial
    begin
        SYS_CLK_I = 1'b0;
        forever #25 SYS_CLK_I = ~SYS_CLK_I;
    end

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    always @(posedge SYS_CLK_I)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            $display("hang cut short");
            conclude;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // bready and rready stay high, so the loops end on the answer edge
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        AWADDR_I <= a;
        WDATA_I <= v;
        AWVALID_I <= 1'b1;
        WVALID_I <= 1'b1;
        do
        begin
            @(posedge SYS_CLK_I);
            if (AWVALID_I && AWREADY_O) AWVALID_I <= 1'b0;
            if (WVALID_I && WREADY_O) WVALID_I <= 1'b0;
        end
        while (!BVALID_O);
        r = BRESP_O;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        ARADDR_I <= a;
        ARVALID_I <= 1'b1;
        do
        begin
            @(posedge SYS_CLK_I);
            if (ARVALID_I && ARREADY_O) ARVALID_I <= 1'b0;
        end
        while (!RVALID_O);
        d = RDATA_O;
        r = RRESP_O;
    endtask : rd

    function automatic logic [31:0] pat(input int i);
        return 32'hA5C3_0000 + i;
    endfunction : pat

    task automatic t_pointers;
        rd(`IBC_ADDR_CSR1);
        check(d, `IBC_CSR1_RST);
        for (int i = 0; i < 5; i++) wr(`IBC_ADDR_ACC, pat(i));
        rd(`IBC_ADDR_CSR0);
        check(d, 32'h0500_0000);
        rd(`IBC_ADDR_ACC);
        check(d, pat(0));
        rd(`IBC_ADDR_ACC);
        check(d, pat(1));
        rd(`IBC_ADDR_CSR0);
        check(d, 32'h0502_0000);
        wr(`IBC_ADDR_CSR0, 32'h0040_0000);
        rd(`IBC_ADDR_CSR0);
        check(d, 32'h0500_0000);
        wr(`IBC_ADDR_CSR0, 32'h4000_0000);
        rd(`IBC_ADDR_CSR0);
        check(d, 32'h0000_0000);
        $display("t_pointers done");
    endtask : t_pointers

    task automatic t_fill;
        for (int i = 0; i < 3; i++) wr(`IBC_ADDR_ACC, pat(10 + i));
        wr(`IBC_ADDR_CSR0, 32'h0000_0080);
        do rd(`IBC_ADDR_CSR0);
        while (d[29:24] !== 6'h00);
        wr(`IBC_ADDR_CSR0, 32'h0040_0000);
        for (int i = 0; i < 64; i++)
        begin
            rd(`IBC_ADDR_ACC);
            check(d, (i < 3) ? pat(10 + i) : `IBC_FILL_WORD);
        end
        $display("t_fill done");
    endtask : t_fill

    task automatic t_reserved;
        wr(`IBC_ADDR_CSR0, 32'hFFFF_FF3F);
        rd(`IBC_ADDR_CSR0);
        check(d, 32'h0000_073F);
        wr(`IBC_ADDR_CSR1, 32'hFFFF_FFFF);
        rd(`IBC_ADDR_CSR1);
        check(d, 32'h0000_FFFF);
        wr(12'h0F0, 32'h1234_5678);
        check(r, `IBC_RESP_SLVERR);
        rd(12'h0F0);
        check(r, `IBC_RESP_SLVERR);
        check(d, 32'h0000_0000);
        $display("t_reserved done");
    endtask : t_reserved

    task automatic t_insert;
        int drop;
        wr(`IBC_ADDR_CSR0, 32'h4040_0000);
        for (int i = 0; i < 8; i++) wr(`IBC_ADDR_ACC, pat(20 + i));
        rd(`IBC_ADDR_ACC);
        wr(`IBC_ADDR_CSR1, 32'h0000_1010);
        ts_on <= 1'b1;
        slow <= 1'b1;
        wr(`IBC_ADDR_CSR0, 32'h0000_0548);
        rd(`IBC_ADDR_CSR0);
        check(d, 32'h0000_0548);
        wr(`IBC_ADDR_ACC, 32'hDEAD_BEEF);
        wr(`IBC_ADDR_CSR0, 32'h4040_0548);
        rd(`IBC_ADDR_CSR0);
        check(d, 32'h0000_0548);
        repeat (200) @(posedge SYS_CLK_I);
        check(u_far.rx_n, 0);
        ts_on <= 1'b0;
        drop = u_far.clk_n;
        do rd(`IBC_ADDR_CSR0);
        while (d[6] !== 1'b0);
        while (u_far.rx_n < 8) @(posedge SYS_CLK_I);
        repeat (20) @(posedge SYS_CLK_I);
        check(u_far.rx_n, 8);
        for (int i = 0; i < 8; i++)
        begin
            check(u_far.rx_data[i], pat(20 + i));
            check({u_far.rx_buf[i], u_far.rx_last[i]}, {3'h5, i == 7});
        end
        check(u_far.first_at - drop >= 3088 && u_far.first_at - drop < 3100, 1);
        $display("t_insert done");
    endtask : t_insert

    initial
    begin
        {AWADDR_I, ARADDR_I, WDATA_I, AWVALID_I, WVALID_I, ARVALID_I} = '0;
        {ts_on, slow, err_count, n_compared, cyc} = '0;
        WSTRB_I = 4'hF;
        BREADY_I = 1'b1;
        RREADY_I = 1'b1;
        RST_N_I = 1'b0;
        repeat (6) @(posedge SYS_CLK_I);
        RST_N_I <= 1'b1;
        @(posedge SYS_CLK_I);
        t_pointers;
        t_fill;
        t_reserved;
        t_insert;
        conclude;
    end
endmodule : tb_ibc_top
